// file: rtl/acc_top.sv
// Summary of operation
// - control bits 3..1 route one of six sources to the negative input
// - control bit 0 routes the positive pin (1) or ladder reference (0)
// - bit 7 enables; negative code 000 picks pin a; positive 0 picks ladder
// - negative code 011 picks ladder; positive 1 picks pin; bit 4 inverts
// - select bit 7 forces the result onto the output pin, either direction
// - control bit 5 picks direct or timer8-clock sampled result
// - control bit 4 inverts the result polarity
// - result reads at control bit 6 and can raise the interrupt
// - select bits 5..4 pick ladder bounds, bits 3..0 one of 16 taps
// - range 00: reference is 1/4 plus (n+1)/32 of supply
// - range 10: reference is 1/5 plus (n+1)/40 of supply
`timescale 1ns/1ns
module acc_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic cmp_raw,
    input wire logic timer8_clock,
    output logic cmp_enable,
    output logic neg_sel_pin_a,
    output logic neg_sel_shared,
    output logic neg_sel_fixed_ref,
    output logic neg_sel_ladder,
    output logic neg_sel_pin_c,
    output logic neg_sel_pin_d,
    output logic pos_sel_pin,
    output logic [5:0] ref_num,
    output logic [5:0] ref_den,
    output logic comparator_output_pin_o,
    output logic comparator_output_pin_oe,
    output logic irq
);
    acc_pkg::acc_top_state_t s_reg;
    acc_pkg::acc_top_state_t s_next;
    logic [1:0] events;
    logic [7:0] ctrl_view;

    acc_if link ();

    acc_cond u_cond (
        .clk(clk),
        .srst(srst),
        .cmp_raw(cmp_raw),
        .timer8_clock(timer8_clock),
        .bus(link.cond)
    );

    acc_ladder u_ladder (
        .clk(clk),
        .srst(srst),
        .bus(link.ladder)
    );

    assign link.ctrl = s_reg.ctrl;
    assign link.sel = s_reg.sel;

    always_comb begin
        s_next = s_reg;
        events = '0;
        events[acc_pkg::STAT_RISE] = link.rise;
        events[acc_pkg::STAT_FALL] = link.fall;
        ctrl_view = s_reg.ctrl;
        ctrl_view[acc_pkg::CTRL_RES] = link.result;
        if (bus_wr) begin
            case (bus_addr)
                acc_pkg::ADDR_CTRL: s_next.ctrl = bus_wdata & acc_pkg::CTRL_WMASK;
                acc_pkg::ADDR_SEL: s_next.sel = bus_wdata;
                acc_pkg::ADDR_MASK: s_next.mask = bus_wdata[1:0];
                default: s_next.mask = s_reg.mask;
            endcase
        end
        s_next.rdata = acc_pkg::RDATA_IDLE;
        if (bus_rd) begin
            case (bus_addr)
                acc_pkg::ADDR_CTRL: s_next.rdata = ctrl_view;
                acc_pkg::ADDR_SEL: s_next.rdata = s_reg.sel;
                acc_pkg::ADDR_STAT: s_next.rdata = {6'h00, s_reg.stat};
                default: s_next.rdata = {6'h00, s_reg.mask};
            endcase
        end
        // a read clears status, but an event in the same cycle survives
        if (bus_rd && bus_addr == acc_pkg::ADDR_STAT) begin
            s_next.stat = acc_pkg::STAT_RST;
        end
        s_next.stat = s_next.stat | events;
        s_next.irq = |(s_next.stat & s_next.mask);
        s_next.pin_o = link.result;
        s_next.pin_oe = s_reg.sel[acc_pkg::SEL_PIN_OUT];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.ctrl <= acc_pkg::CTRL_RST;
            s_reg.sel <= acc_pkg::SEL_RST;
            s_reg.mask <= acc_pkg::MASK_RST;
            s_reg.stat <= acc_pkg::STAT_RST;
            s_reg.rdata <= acc_pkg::RDATA_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata = s_reg.rdata;
    assign cmp_enable = s_reg.ctrl[acc_pkg::CTRL_EN];
    assign neg_sel_pin_a = link.neg_oh[acc_pkg::NEGB_PIN_A];
    assign neg_sel_shared = link.neg_oh[acc_pkg::NEGB_SHARED];
    assign neg_sel_fixed_ref = link.neg_oh[acc_pkg::NEGB_FIXED_REF];
    assign neg_sel_ladder = link.neg_oh[acc_pkg::NEGB_LADDER];
    assign neg_sel_pin_c = link.neg_oh[acc_pkg::NEGB_PIN_C];
    assign neg_sel_pin_d = link.neg_oh[acc_pkg::NEGB_PIN_D];
    assign pos_sel_pin = link.pos_pin;
    assign ref_num = link.ref_num;
    assign ref_den = link.ref_den;
    assign comparator_output_pin_o = s_reg.pin_o;
    assign comparator_output_pin_oe = s_reg.pin_oe;
    assign irq = s_reg.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence ctrl_write_s(logic [7:0] v);
        bus_wr && bus_addr == acc_pkg::ADDR_CTRL && bus_wdata == v;
    endsequence

    sequence sel_steady_s;
        $stable(s_reg.sel)[*2];
    endsequence

    sequence direct_inverted_s;
        (s_reg.ctrl[acc_pkg::CTRL_EN] && s_reg.ctrl[acc_pkg::CTRL_INV]
            && !s_reg.ctrl[acc_pkg::CTRL_SAMP] && $stable(s_reg.ctrl)
            && $stable(cmp_raw))[*3];
    endsequence

    neg_onehot_a: assert property (
        $onehot({neg_sel_pin_a, neg_sel_shared, neg_sel_fixed_ref,
            neg_sel_ladder, neg_sel_pin_c, neg_sel_pin_d}))
        else $error("negative input route is not one-hot");

    neg_code_a: assert property (
        bus_wr && bus_addr == acc_pkg::ADDR_CTRL
            && bus_wdata[3:1] == acc_pkg::NEG_FIXED_REF
        |-> ##2 neg_sel_fixed_ref)
        else $error("fixed reference not routed two cycles after write");

    pos_route_a: assert property (
        bus_wr && bus_addr == acc_pkg::ADDR_CTRL
        |-> ##2 pos_sel_pin == $past(bus_wdata[acc_pkg::CTRL_POS], 2))
        else $error("positive input route does not follow control bit 0");

    enable_pin_a: assert property (
        ctrl_write_s(8'h80)
        |-> ##1 cmp_enable ##1 (neg_sel_pin_a && !pos_sel_pin))
        else $error("enable with pin a and ladder reference not applied");

    ladder_inv_a: assert property (
        ctrl_write_s(8'h97)
        |-> ##1 (cmp_enable && s_reg.ctrl[acc_pkg::CTRL_INV])
            ##1 (neg_sel_ladder && pos_sel_pin))
        else $error("ladder negative with inverted pin positive not applied");

    pin_force_a: assert property (
        bus_wr && bus_addr == acc_pkg::ADDR_SEL
        |-> ##2 comparator_output_pin_oe == $past(bus_wdata[acc_pkg::SEL_PIN_OUT], 2))
        else $error("output pin enable does not follow select bit 7");

    pin_value_a: assert property (
        comparator_output_pin_oe |-> comparator_output_pin_o == $past(link.result))
        else $error("output pin does not carry the result");

    invert_path_a: assert property (
        direct_inverted_s |-> comparator_output_pin_o == !cmp_raw)
        else $error("inverted direct result wrong on the pin");

    direct_path_a: assert property (
        (s_reg.ctrl[acc_pkg::CTRL_EN] && !s_reg.ctrl[acc_pkg::CTRL_INV]
            && !s_reg.ctrl[acc_pkg::CTRL_SAMP] && $stable(s_reg.ctrl)
            && $stable(cmp_raw))[*3]
        |-> comparator_output_pin_o == cmp_raw)
        else $error("direct result does not follow the comparator");

    disabled_low_a: assert property (
        (!s_reg.ctrl[acc_pkg::CTRL_EN])[*3] |-> !link.result)
        else $error("result high while comparator disabled");

    result_read_a: assert property (
        bus_rd && bus_addr == acc_pkg::ADDR_CTRL
        |=> bus_rdata[acc_pkg::CTRL_RES] == $past(link.result))
        else $error("control bit 6 does not read the result");

    irq_level_a: assert property (
        link.rise && s_reg.mask[acc_pkg::STAT_RISE]
            && !(bus_wr && bus_addr == acc_pkg::ADDR_MASK)
        |=> irq && s_reg.stat[acc_pkg::STAT_RISE])
        else $error("unmasked rising result did not raise the interrupt");

    stat_clear_a: assert property (
        bus_rd && bus_addr == acc_pkg::ADDR_STAT && !link.rise && !link.fall
        |=> s_reg.stat == acc_pkg::STAT_RST && bus_rdata == {6'h00, $past(s_reg.stat)})
        else $error("status not cleared by its read");

    quarter_range_a: assert property (
        sel_steady_s ##0 s_reg.sel[5:4] == acc_pkg::RANGE_QUARTER
        |-> ref_den == acc_pkg::DEN_QUARTER
            && ref_num == {2'h0, s_reg.sel[3:0]} + acc_pkg::LADDER_OFF_BOUNDED)
        else $error("quarter range reference wrong");

    fifth_range_a: assert property (
        sel_steady_s ##0 s_reg.sel[5:4] == acc_pkg::RANGE_FIFTH
        |-> ref_den == acc_pkg::DEN_FIFTH
            && ref_num == {2'h0, s_reg.sel[3:0]} + acc_pkg::LADDER_OFF_BOUNDED)
        else $error("fifth range reference wrong");

    full_range_a: assert property (
        sel_steady_s ##0 s_reg.sel[4]
        |-> ref_num == {2'h0, s_reg.sel[3:0]} + acc_pkg::LADDER_OFF_FULL
            && ref_den == (s_reg.sel[5] ? acc_pkg::DEN_FULL32 : acc_pkg::DEN_FULL24))
        else $error("full-span range reference wrong");

    tap_bound_a: assert property (
        ref_num <= ref_den && ref_num != 6'h00)
        else $error("ladder tap outside its bounds");
endmodule

// file: rtl/acc_pkg.sv
package acc_pkg;
    // register indices on the byte-wide register port
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_SEL = 2'h1;
    localparam logic [1:0] ADDR_STAT = 2'h2;
    localparam logic [1:0] ADDR_MASK = 2'h3;

    // comparator_control fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_RES = 6;
    localparam int CTRL_SAMP = 5;
    localparam int CTRL_INV = 4;
    localparam int CTRL_NEG_HI = 3;
    localparam int CTRL_NEG_LO = 1;
    localparam int CTRL_POS = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;

    // comparator_select fields
    localparam int SEL_PIN_OUT = 7;
    localparam int SEL_RANGE_HI = 5;
    localparam int SEL_RANGE_LO = 4;
    localparam int SEL_TAP_HI = 3;
    localparam int SEL_TAP_LO = 0;

    // interrupt status and mask fields
    localparam int STAT_RISE = 0;
    localparam int STAT_FALL = 1;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // negative-input codes and one-hot route positions
    localparam logic [2:0] NEG_PIN_A = 3'h0;
    localparam logic [2:0] NEG_SHARED = 3'h1;
    localparam logic [2:0] NEG_FIXED_REF = 3'h2;
    localparam logic [2:0] NEG_LADDER = 3'h3;
    localparam logic [2:0] NEG_PIN_C = 3'h4;
    localparam logic [2:0] NEG_PIN_D = 3'h5;
    localparam int NEG_N = 6;
    localparam int NEGB_PIN_A = 0;
    localparam int NEGB_SHARED = 1;
    localparam int NEGB_FIXED_REF = 2;
    localparam int NEGB_LADDER = 3;
    localparam int NEGB_PIN_C = 4;
    localparam int NEGB_PIN_D = 5;

    // ladder range codes, offsets in taps and denominators
    localparam logic [1:0] RANGE_QUARTER = 2'h0;
    localparam logic [1:0] RANGE_FULL24 = 2'h1;
    localparam logic [1:0] RANGE_FIFTH = 2'h2;
    localparam logic [1:0] RANGE_FULL32 = 2'h3;
    localparam logic [5:0] LADDER_OFF_BOUNDED = 6'h09;
    localparam logic [5:0] LADDER_OFF_FULL = 6'h01;
    localparam logic [5:0] DEN_QUARTER = 6'h20;
    localparam logic [5:0] DEN_FULL24 = 6'h18;
    localparam logic [5:0] DEN_FIFTH = 6'h28;
    localparam logic [5:0] DEN_FULL32 = 6'h20;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sel;
        logic [1:0] mask;
        logic [1:0] stat;
        logic [7:0] rdata;
        logic pin_o;
        logic pin_oe;
        logic irq;
    } acc_top_state_t;

    typedef struct packed {
        logic tclk_prev;
        logic samp;
        logic res;
        logic res_d;
    } acc_cond_state_t;

    typedef struct packed {
        logic [5:0] num;
        logic [5:0] den;
        logic [NEG_N-1:0] neg_oh;
        logic pos_pin;
    } acc_ladder_state_t;
endpackage

// file: rtl/acc_if.sv
`timescale 1ns/1ns
interface acc_if;
    logic [7:0] ctrl;
    logic [7:0] sel;
    logic result;
    logic rise;
    logic fall;
    logic [5:0] ref_num;
    logic [5:0] ref_den;
    logic [acc_pkg::NEG_N-1:0] neg_oh;
    logic pos_pin;

    modport top (
        output ctrl,
        output sel,
        input result,
        input rise,
        input fall,
        input ref_num,
        input ref_den,
        input neg_oh,
        input pos_pin
    );
    modport cond (
        input ctrl,
        output result,
        output rise,
        output fall
    );
    modport ladder (
        input ctrl,
        input sel,
        output ref_num,
        output ref_den,
        output neg_oh,
        output pos_pin
    );
endinterface

// file: rtl/acc_cond.sv
`timescale 1ns/1ns
module acc_cond (
    input wire logic clk,
    input wire logic srst,
    input wire logic cmp_raw,
    input wire logic timer8_clock,
    acc_if.cond bus
);
    acc_pkg::acc_cond_state_t s_reg;
    acc_pkg::acc_cond_state_t s_next;
    logic tedge;
    logic cond;

    always_comb begin
        s_next = s_reg;
        tedge = timer8_clock & ~s_reg.tclk_prev;
        // disabled comparator presents a low result
        cond = bus.ctrl[acc_pkg::CTRL_EN] & (cmp_raw ^ bus.ctrl[acc_pkg::CTRL_INV]);
        s_next.tclk_prev = timer8_clock;
        if (tedge) begin
            s_next.samp = cond;
        end
        // a held sample must not leak out once the comparator is disabled
        s_next.res = bus.ctrl[acc_pkg::CTRL_EN]
            & (bus.ctrl[acc_pkg::CTRL_SAMP] ? s_reg.samp : cond);
        s_next.res_d = s_reg.res;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.result = s_reg.res;
    assign bus.rise = s_reg.res & ~s_reg.res_d;
    assign bus.fall = ~s_reg.res & s_reg.res_d;

    samp_hold_a: assert property (
        @(posedge clk) disable iff (srst)
        (bus.ctrl[acc_pkg::CTRL_SAMP] && !tedge)[*2] |-> $stable(s_reg.samp))
        else $error("sample changed without a timer edge");
endmodule

// file: rtl/acc_ladder.sv
`timescale 1ns/1ns
module acc_ladder (
    input wire logic clk,
    input wire logic srst,
    acc_if.ladder bus
);
    acc_pkg::acc_ladder_state_t s_reg;
    acc_pkg::acc_ladder_state_t s_next;
    logic [5:0] tap;

    always_comb begin
        s_next = s_reg;
        tap = {2'h0, bus.sel[acc_pkg::SEL_TAP_HI:acc_pkg::SEL_TAP_LO]};
        case (bus.sel[acc_pkg::SEL_RANGE_HI:acc_pkg::SEL_RANGE_LO])
            acc_pkg::RANGE_QUARTER: begin
                s_next.num = tap + acc_pkg::LADDER_OFF_BOUNDED;
                s_next.den = acc_pkg::DEN_QUARTER;
            end
            acc_pkg::RANGE_FULL24: begin
                s_next.num = tap + acc_pkg::LADDER_OFF_FULL;
                s_next.den = acc_pkg::DEN_FULL24;
            end
            acc_pkg::RANGE_FIFTH: begin
                s_next.num = tap + acc_pkg::LADDER_OFF_BOUNDED;
                s_next.den = acc_pkg::DEN_FIFTH;
            end
            default: begin
                s_next.num = tap + acc_pkg::LADDER_OFF_FULL;
                s_next.den = acc_pkg::DEN_FULL32;
            end
        endcase
        s_next.neg_oh = '0;
        case (bus.ctrl[acc_pkg::CTRL_NEG_HI:acc_pkg::CTRL_NEG_LO])
            acc_pkg::NEG_PIN_A: s_next.neg_oh[acc_pkg::NEGB_PIN_A] = 1'b1;
            acc_pkg::NEG_SHARED: s_next.neg_oh[acc_pkg::NEGB_SHARED] = 1'b1;
            acc_pkg::NEG_FIXED_REF: s_next.neg_oh[acc_pkg::NEGB_FIXED_REF] = 1'b1;
            acc_pkg::NEG_PIN_C: s_next.neg_oh[acc_pkg::NEGB_PIN_C] = 1'b1;
            acc_pkg::NEG_PIN_D: s_next.neg_oh[acc_pkg::NEGB_PIN_D] = 1'b1;
            // unused codes fall back to the ladder
            default: s_next.neg_oh[acc_pkg::NEGB_LADDER] = 1'b1;
        endcase
        s_next.pos_pin = bus.ctrl[acc_pkg::CTRL_POS];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
            s_reg.neg_oh[acc_pkg::NEGB_PIN_A] <= 1'b1;
            s_reg.num <= acc_pkg::LADDER_OFF_BOUNDED;
            s_reg.den <= acc_pkg::DEN_QUARTER;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.ref_num = s_reg.num;
    assign bus.ref_den = s_reg.den;
    assign bus.neg_oh = s_reg.neg_oh;
    assign bus.pos_pin = s_reg.pos_pin;
endmodule

// file: test/acc_analog_model.sv
`timescale 1ns/1ns
module acc_analog_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic level_req,
    input wire logic tick_run,
    input wire logic [3:0] tick_div,
    output logic cmp_raw,
    output logic timer8_clock
);
    logic [3:0] cnt;

    // comparator settles one cycle after its inputs move
    // input pins carry no digital input load here, so no leakage path is modelled
    always_ff @(posedge clk) begin
        cmp_raw <= level_req;
        if (srst) begin
            cnt <= 4'h0;
            timer8_clock <= 1'b0;
        end else if (tick_run) begin
            // a larger tick_div gives a slower timer clock
            if (cnt == tick_div) begin
                cnt <= 4'h0;
                timer8_clock <= ~timer8_clock;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// file: test/analog_comparator_control_bench.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_count++; $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module analog_comparator_control_bench;
    logic clk, srst, bus_wr, bus_rd, cmp_raw, timer8_clock, level_req, tick_run;
    logic [1:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, ctrl_w, sel_w;
    logic cmp_enable, neg_sel_pin_a, neg_sel_shared, neg_sel_fixed_ref, neg_sel_ladder;
    logic neg_sel_pin_c, neg_sel_pin_d, pos_sel_pin, pin_o, pin_oe, irq, armed, res;
    logic rd_seen = 1'b0;
    logic [5:0] ref_num, ref_den, neg_vec;
    logic [3:0] tick_div, tap;
    logic [15:0] note;
    logic [31:0] rng;
    logic [15:0] notes[$];
    logic [5:0] dens[4] = '{6'h20, 6'h18, 6'h28, 6'h20};
    int err_count, n_tests;

    assign neg_vec = {neg_sel_pin_d, neg_sel_pin_c, neg_sel_ladder, neg_sel_fixed_ref,
                      neg_sel_shared, neg_sel_pin_a};

    acc_top i_dut (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_raw(cmp_raw),
        .timer8_clock(timer8_clock), .cmp_enable(cmp_enable), .neg_sel_pin_a(neg_sel_pin_a),
        .neg_sel_shared(neg_sel_shared), .neg_sel_fixed_ref(neg_sel_fixed_ref),
        .neg_sel_ladder(neg_sel_ladder), .neg_sel_pin_c(neg_sel_pin_c),
        .neg_sel_pin_d(neg_sel_pin_d), .pos_sel_pin(pos_sel_pin), .ref_num(ref_num),
        .ref_den(ref_den), .comparator_output_pin_o(pin_o),
        .comparator_output_pin_oe(pin_oe), .irq(irq));

    acc_analog_model i_model (.clk(clk), .srst(srst), .level_req(level_req),
        .tick_run(tick_run), .tick_div(tick_div), .cmp_raw(cmp_raw),
        .timer8_clock(timer8_clock));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    // care selects the bits of the answer that are compared
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] care);
        notes.push_back({care, e & care});
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
    endtask

    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge clk) begin
        rd_seen <= bus_rd;
        if (rd_seen) begin
            note = notes.pop_front();
            `CHK(bus_rdata & note[15:8], note[7:0])
        end else if (armed) begin
            `CHK(bus_rdata, 8'h00)
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #(50 * 20000);
        err_count++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        bus_addr = 2'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        level_req = 1'b0;
        tick_run = 1'b0;
        tick_div = 4'h1;
        rng = 32'h00000054;
        armed = 1'b0;
        err_count = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        armed <= 1'b1;
        wait_n(1);
        `CHK({cmp_enable, neg_vec, pos_sel_pin, pin_oe, irq}, 10'h008)
        `CHK({ref_num, ref_den}, {6'h09, 6'h20})
        for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00, 8'hff);
        // every negative code with both positive routes
        for (int c = 0; c < 16; c++) begin
            ctrl_w = {4'h8, c[3:0]};
            wr(acc_pkg::ADDR_CTRL, ctrl_w);
            wait_n(3);
            `CHK({cmp_enable, pos_sel_pin}, {1'b1, ctrl_w[0]})
            `CHK(neg_vec, (c[3:1] > 5) ? 6'h08 : (6'h01 << c[3:1]))
            rd(acc_pkg::ADDR_CTRL, ctrl_w, 8'hff);
        end
        // every range with lowest, highest and random taps
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                rng = xs(rng);
                tap = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : rng[3:0];
                sel_w = {rng[7], 1'b0, r[1:0], tap};
                wr(acc_pkg::ADDR_SEL, sel_w);
                wait_n(3);
                `CHK(ref_num, (r[0] ? 6'h01 : 6'h09) + {2'b00, tap})
                `CHK(ref_den, dens[r])
                `CHK(pin_oe, rng[7])
                rd(acc_pkg::ADDR_SEL, sel_w, 8'hff);
            end
        end
        // worked settings: pin a against 18/32, then inverted ladder 22/40 against the pin
        wr(acc_pkg::ADDR_SEL, 8'h09);
        wr(acc_pkg::ADDR_CTRL, 8'h80);
        wait_n(3);
        `CHK({cmp_enable, neg_vec, pos_sel_pin}, 8'h82)
        `CHK({ref_num, ref_den}, {6'h12, 6'h20})
        wr(acc_pkg::ADDR_SEL, 8'had);
        wr(acc_pkg::ADDR_CTRL, 8'h97);
        wait_n(4);
        `CHK({cmp_enable, neg_vec, pos_sel_pin}, 8'h91)
        `CHK({ref_num, ref_den}, {6'h16, 6'h28})
        `CHK({pin_oe, pin_o}, 2'h3)
        rd(acc_pkg::ADDR_CTRL, 8'hd7, 8'hff);
        // direct result, random level and polarity, forced onto the pin
        wr(acc_pkg::ADDR_SEL, 8'h80);
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            level_req <= rng[0];
            ctrl_w = {3'h4, rng[1], 4'h0};
            wr(acc_pkg::ADDR_CTRL, ctrl_w);
            wait_n(4);
            res = rng[0] ^ rng[1];
            `CHK({pin_oe, pin_o}, {1'b1, res})
            rd(acc_pkg::ADDR_CTRL, ctrl_w | {1'b0, res, 6'h00}, 8'hff);
        end
        // disabled comparator reads a cleared result even when inverted
        level_req <= 1'b1;
        wr(acc_pkg::ADDR_CTRL, 8'h10);
        wait_n(4);
        `CHK(pin_o, 1'b0)
        rd(acc_pkg::ADDR_CTRL, 8'h10, 8'hff);
        // sampled mode: held until a timer clock rise
        level_req <= 1'b0;
        wr(acc_pkg::ADDR_CTRL, 8'ha0);
        tick_run <= 1'b1;
        wait_n(8);
        tick_run <= 1'b0;
        wait_n(2);
        level_req <= 1'b1;
        wait_n(6);
        rd(acc_pkg::ADDR_CTRL, 8'ha0, 8'hff);
        `CHK(pin_o, 1'b0)
        tick_div <= 4'h3;
        tick_run <= 1'b1;
        wait_n(12);
        tick_run <= 1'b0;
        rd(acc_pkg::ADDR_CTRL, 8'he0, 8'hff);
        // interrupt: mask, raise, clear on read, masked event
        wr(acc_pkg::ADDR_MASK, 8'hfd);
        rd(acc_pkg::ADDR_MASK, 8'h01, 8'hff);
        level_req <= 1'b0;
        wr(acc_pkg::ADDR_CTRL, 8'hc0);
        wait_n(4);
        rd(acc_pkg::ADDR_CTRL, 8'h80, 8'hff);
        rd(acc_pkg::ADDR_STAT, 8'h00, 8'h00);
        wait_n(2);
        `CHK(irq, 1'b0)
        level_req <= 1'b1;
        wait_n(5);
        `CHK(irq, 1'b1)
        rd(acc_pkg::ADDR_STAT, 8'h01, 8'hff);
        wait_n(2);
        `CHK(irq, 1'b0)
        level_req <= 1'b0;
        wait_n(5);
        `CHK(irq, 1'b0)
        wr(acc_pkg::ADDR_STAT, 8'h00);
        rd(acc_pkg::ADDR_STAT, 8'h02, 8'hff);
        rd(acc_pkg::ADDR_STAT, 8'h00, 8'hff);
        wr(acc_pkg::ADDR_SEL, 8'h00);
        wait_n(3);
        `CHK(pin_oe, 1'b0)
        wait_n(3);
        test_done();
    end
endmodule
